// ---- bench/sst_console_model.sv ----
// Console side model: main clock state and power-up code
`timescale 1ns/10ps
module sst_console_model (
   // Clock and operator keys
   input  wire logic       clk_in,
   input  wire logic       run_key_in,
   input  wire logic       code_key_in,
   // Console state
   output logic            main_run_out,
   output logic [6:0]      code_out
);
   // Main clock lags the key by one cycle, as a real console would
   always_ff @(posedge clk_in) begin
      main_run_out <= run_key_in;
   end
   assign code_out = code_key_in ? 7'h64 : 7'h05;
endmodule : sst_console_model

// ---- bench/sst_timer_test.sv ----
// Self-checking bench of the segment sequence timer
`timescale 1ns/10ps
`include "sst_map.svh"
module sst_timer_test;
   logic               clk_in;
   logic               resetn_in;
   logic [7:0]         addr;
   logic [31:0]        wdata;
   logic               wr;
   logic               rd;
   logic [31:0]        rdata;
   logic               run_key;
   logic               code_key;
   logic               main_run;
   logic [6:0]         code;
   logic               active;
   logic               running;
   logic [31:0]        d;
   int                 mismatches;
   int                 cmp_count;
   int                 i;
   sst_pkg::sst_disp_t disp;
   sst_console_model i_con (.clk_in(clk_in), .run_key_in(run_key), .code_key_in(code_key),
      .main_run_out(main_run), .code_out(code));
   // Short tick keeps each second at ten cycles
   sst_timer #(.TICK_CYCLES(10)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .main_clock_running_in(main_run), .program_code_in(code), .display_out(disp),
      .seq_active_out(active), .running_out(running));
   task automatic final_report();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic settle();
      @(posedge clk_in);
      #1;
   endtask : settle
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask : wr_reg
   // Read data stand only in the cycle after the strobe
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, e);
      @(posedge clk_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1;
      chk(n, rdata & m, e);
   endtask : rc
   task automatic do_reset();
      resetn_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
   endtask : do_reset
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      #20000;
      mismatches++;
      final_report();
   end
   initial begin
      resetn_in = 1'b0;
      addr      = 8'h00;
      wdata     = 32'h0;
      wr        = 1'b0;
      rd        = 1'b0;
      run_key   = 1'b1;
      code_key  = 1'b0;
      do_reset();
      rc("cfg", `SST_OFS_CFG, 32'h7, 32'h4);
      rc("first", `SST_OFS_FIRST, 32'h7F, 32'h1);
      rc("last", `SST_OFS_LAST, 32'h7F, 32'h63);
      rc("warn", `SST_OFS_WARN, 32'h1FFF, 32'h0);
      rc("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
      wr_reg(`SST_OFS_ENTRY, 32'h1);
      wr_reg(`SST_OFS_ENTRY, 32'h2);
      rc("entry running", `SST_OFS_STATUS, 32'h4, 32'h0);
      @(posedge clk_in) run_key <= 1'b0;
      wr_reg(`SST_OFS_ENTRY, 32'h1);
      rc("single yes", `SST_OFS_STATUS, 32'h4, 32'h0);
      wr_reg(`SST_OFS_ENTRY, 32'h2);
      #1 chk("entry", active, 1'b1);
      wr_reg(`SST_OFS_EIDX, 32'h2);
      wr_reg(`SST_OFS_EVAL, 32'h1);
      wr_reg(`SST_OFS_EVAL, 32'h1);
      wr_reg(`SST_OFS_ECTL, 32'h1);
      rc("edit up", `SST_OFS_INDEX, 32'h7F00, 32'h0300);
      wr_reg(`SST_OFS_ECTL, 32'h2);
      rc("edit down", `SST_OFS_INDEX, 32'h7F00, 32'h0400);
      wr_reg(`SST_OFS_ECTL, 32'h4);
      rc("edit exit", `SST_OFS_STATUS, 32'h8, 32'h0);
      wr_reg(`SST_OFS_FIRST, 32'h2);
      wr_reg(`SST_OFS_LAST, 32'h3);
      wr_reg(`SST_OFS_GAP, 32'h1);
      wr_reg(`SST_OFS_CFG, 32'h5);
      rc("cfg rw", `SST_OFS_CFG, 32'h7, 32'h5);
      wr_reg(`SST_OFS_CMD, 32'h1);
      rc("start", `SST_OFS_INDEX, 32'h7F, 32'h2);
      chk("run", running, 1'b1);
      for (i = 0; i < 60 && disp.guest_on !== 1'b1; i++) settle();
      chk("guest on", disp.guest_on, 1'b1);
      chk("guest gap", disp.guest_time, 13'h0001);
      chk("gap flash", disp.index_flash, 1'b1);
      chk("gap index", disp.index, 7'h02);
      chk("console gap", disp.console_gap, 13'h0001);
      rc("gap time", `SST_OFS_TIME, 32'h1FFF0000, 32'h00010000);
      for (i = 0; i < 60 && disp.index !== 7'h03; i++) settle();
      chk("seg flash", disp.index_flash, 1'b0);
      chk("guest off", disp.guest_on, 1'b0);
      wr_reg(`SST_OFS_CMD, 32'h4);
      rc("rewind run", `SST_OFS_INDEX, 32'h7F, 32'h3);
      for (i = 0; i < 80 && running !== 1'b0; i++) settle();
      rc("reload", `SST_OFS_INDEX, 32'h7F, 32'h2);
      chk("reload time", disp.board_time, 13'h0001);
      // A one-second segment sits inside a one-second warning window
      wr_reg(`SST_OFS_WARN, 32'h1);
      settle();
      chk("warn flash", disp.index_flash, 1'b1);
      wr_reg(`SST_OFS_CMD, 32'h10);
      rc("next", `SST_OFS_INDEX, 32'h7F, 32'h3);
      wr_reg(`SST_OFS_CMD, 32'h4);
      rc("rewind", `SST_OFS_INDEX, 32'h7F, 32'h2);
      // Per-segment halt with a zero gap: stop right after segment 2
      wr_reg(`SST_OFS_CFG, 32'h3);
      wr_reg(`SST_OFS_GAP, 32'h0);
      wr_reg(`SST_OFS_CMD, 32'h1);
      settle();
      chk("halt run", running, 1'b1);
      for (i = 0; i < 40 && running !== 1'b0; i++) settle();
      rc("halt index", `SST_OFS_INDEX, 32'h7F, 32'h3);
      chk("halt time", disp.board_time, 13'h0001);
      wr_reg(`SST_OFS_CMD, 32'h1);
      wr_reg(`SST_OFS_CMD, 32'h2);
      settle();
      chk("stop", running, 1'b0);
      wr_reg(`SST_OFS_CMD, 32'h8);
      rc("reload seg", `SST_OFS_TIME, 32'h1FFF, 32'h1);
      wr_reg(`SST_OFS_ENTRY, 32'h4);
      settle();
      chk("leave", active, 1'b0);
      @(posedge clk_in) code_key <= 1'b1;
      do_reset();
      settle();
      settle();
      chk("code", active, 1'b1);
      final_report();
   end
endmodule : sst_timer_test

// ---- inc/sst_map.svh ----
// Register offsets, field positions, reset values and timing counts of the segment timer
`ifndef SST_MAP_SVH
`define SST_MAP_SVH

`define SST_SEG_COUNT      99
`define SST_PROG_CODE      7'h64
`define SST_ADDR_W         8
`define SST_DATA_W         32
`define SST_MMSS_W         13
`define SST_SEC_MAX        6'h3B

`define SST_OFS_CMD        8'h00
`define SST_OFS_CFG        8'h04
`define SST_OFS_FIRST      8'h08
`define SST_OFS_LAST       8'h0C
`define SST_OFS_GAP        8'h10
`define SST_OFS_WARN       8'h14
`define SST_OFS_EIDX       8'h18
`define SST_OFS_EVAL       8'h1C
`define SST_OFS_ECTL       8'h20
`define SST_OFS_ENTRY      8'h24
`define SST_OFS_STATUS     8'h28
`define SST_OFS_TIME       8'h2C
`define SST_OFS_INDEX      8'h30

`define SST_CMD_START      0
`define SST_CMD_STOP       1
`define SST_CMD_REWIND     2
`define SST_CMD_RELOAD     3
`define SST_CMD_NEXT       4

`define SST_CFG_GAPDISP    0
`define SST_CFG_HALT_EACH  1
`define SST_CFG_HALT_LAST  2

`define SST_ECTL_UP        0
`define SST_ECTL_DOWN      1
`define SST_ECTL_EXIT      2

`define SST_ENTRY_REQ      0
`define SST_ENTRY_YES      1
`define SST_ENTRY_LEAVE    2

`define SST_ST_RUN         0
`define SST_ST_GAP         1
`define SST_ST_ACTIVE      2
`define SST_ST_EDIT        3
`define SST_ST_PEND        4
`define SST_ST_FLASH       5

`define SST_TIME_GAP_LSB   16
`define SST_INDEX_EDIT_LSB 8

`define SST_RST_GAPDISP    1'h0
`define SST_RST_HALT_EACH  1'h0
`define SST_RST_HALT_LAST  1'h1
`define SST_RST_FIRST      7'h01
`define SST_RST_LAST       7'h63
`define SST_RST_GAP        13'h0000
`define SST_RST_WARN       13'h0000

`define SST_CLK_FREQ_HZ    250000000
`define SST_TICK_PERIOD_MS 1000
`define SST_TICK_CYCLES    (`SST_CLK_FREQ_HZ / 1000 * `SST_TICK_PERIOD_MS)

`endif

// ---- inc/sst_pkg.sv ----
// Types shared by the segment timer modules
package sst_pkg;

   typedef struct packed {
      logic [6:0] min;
      logic [5:0] sec;
   } sst_mmss_t;

   typedef enum logic [1:0] {
      PH_SEG = 2'b01,
      PH_GAP = 2'b10
   } sst_phase_t;

   typedef struct packed {
      sst_mmss_t  board_time;
      sst_mmss_t  guest_time;
      logic       guest_on;
      sst_mmss_t  console_gap;
      logic [6:0] index;
      logic       index_flash;
   } sst_disp_t;

endpackage : sst_pkg

// ---- rtl/sst_mmss_dec.sv ----
// Minutes:seconds one-second decrementer with borrow
`timescale 1ns/10ps
`include "sst_map.svh"

module sst_mmss_dec (
   // Value
   input  wire sst_pkg::sst_mmss_t value_in,
   output sst_pkg::sst_mmss_t      value_out,
   output logic                    zero_out
);

   always_comb begin
      value_out = value_in;
      zero_out  = (value_in == '0);
      if (value_in.sec != 6'h00) begin
         value_out.sec = value_in.sec - 6'h01;
      end else if (value_in.min != 7'h00) begin
         // Borrow a minute into the seconds field
         value_out.min = value_in.min - 7'h01;
         value_out.sec = `SST_SEC_MAX;
      end
   end

endmodule : sst_mmss_dec

// ---- rtl/sst_tick_gen.sv ----
// One-second tick generator for the segment timer
`timescale 1ns/10ps
`include "sst_map.svh"

module sst_tick_gen #(
   parameter int unsigned TICK_CYCLES = `SST_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Tick
   output logic      tick_out
);

   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] count_reg;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         count_reg <= '0;
         tick_out  <= 1'b0;
      end else if (count_reg == LAST) begin
         count_reg <= '0;
         tick_out  <= 1'b1;
      end else begin
         count_reg <= CW'(count_reg + 1'b1);
         tick_out  <= 1'b0;
      end
   end

   AST_TICK_SPACING: assert property (@(posedge clk_in) disable iff (!resetn_in)
      tick_out |-> $past(count_reg) == LAST)
      else $error("tick not one period after the last");

endmodule : sst_tick_gen

// ---- rtl/sst_timer.sv ----
// Segment sequence timer: duration table, sequencer, edit, entry and register port
//
// Behaviour
// - Hold 99 programmable segment durations and run the sequence from them.
// - On the first start after activation load the first-index segment duration and count down.
// - After a segment hits zero count the gap, then advance and count.
// - After the last segment reload the first index; run on or wait.
// - Durations survive power loss and are shared by every sport program.
// - Sport entry only with main clock stopped, after a second confirming yes.
// - Program code 100 at power-up starts the dedicated sequencer.
// - Edit takes index then time; each enter stores and steps; exit ends.
// - Up and down arrows move the edited index to previous or next.
// - Store operator first and last index bounding the executed range.
// - Rewind command puts the current index back to the first index.
// - Gap editable as minutes:seconds, routed to guest digits when shown.
// - Gap not shown: console only; gap shown: also on the scoreboard.
// - Gap always counted; a zero gap gives no pause.
// - Flash the segment index while gap time is on the scoreboard.
// - Per-segment halt stops after each segment; otherwise continue.
// - End halt stops after the last segment; otherwise restart at first.
// - Rewind is ignored while the clock runs.
// - Nonzero warning time flashes the index until zero; 00:00 disables.
`timescale 1ns/10ps
`include "sst_map.svh"

module sst_timer #(
   parameter int unsigned TICK_CYCLES = `SST_TICK_CYCLES,
   parameter int unsigned SEG_COUNT   = `SST_SEG_COUNT
) (
   // Clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      resetn_in,
   // Register port
   input  wire logic [`SST_ADDR_W-1:0]    addr_in,
   input  wire logic [`SST_DATA_W-1:0]    wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [`SST_DATA_W-1:0]    rdata_out,
   // Console state
   input  wire logic                      main_clock_running_in,
   input  wire logic [6:0]                program_code_in,
   // Display and status
   output sst_pkg::sst_disp_t             display_out,
   output logic                           seq_active_out,
   output logic                           running_out
);

   localparam logic [6:0] IDX_MAX = 7'(SEG_COUNT);
   localparam logic [6:0] IDX_MIN = 7'h01;

   function automatic logic [6:0] idx_inc(input logic [6:0] i);
      return (i >= IDX_MAX) ? IDX_MIN : 7'(i + 7'h01);
   endfunction : idx_inc

   function automatic logic [6:0] idx_dec(input logic [6:0] i);
      return (i <= IDX_MIN) ? IDX_MAX : 7'(i - 7'h01);
   endfunction : idx_dec

   function automatic logic [6:0] idx_clamp(input logic [6:0] i);
      return (i < IDX_MIN) ? IDX_MIN : ((i > IDX_MAX) ? IDX_MAX : i);
   endfunction : idx_clamp

   // Durations live in an always-on retention domain; no reset touches them
   sst_pkg::sst_mmss_t seg_table [1:SEG_COUNT];

   logic               gapdisp_reg;
   logic               halt_each_reg;
   logic               halt_last_reg;
   logic [6:0]         first_reg;
   logic [6:0]         last_reg;
   sst_pkg::sst_mmss_t gap_reg;
   sst_pkg::sst_mmss_t warn_reg;
   logic [6:0]         edit_idx_reg;
   logic               edit_active_reg;
   logic               entry_pend_reg;
   logic               seq_active_reg;
   logic               strap_done_reg;
   logic               running_reg;
   sst_pkg::sst_phase_t phase_reg;
   logic               need_load_reg;
   logic [6:0]         idx_reg;
   sst_pkg::sst_mmss_t seg_time_reg;
   sst_pkg::sst_mmss_t gap_time_reg;
   sst_pkg::sst_disp_t display_reg;
   logic [`SST_DATA_W-1:0] rdata_reg;

   logic               tick;
   sst_pkg::sst_mmss_t seg_dec;
   sst_pkg::sst_mmss_t gap_dec;
   logic               seg_zero;
   logic               gap_zero;

   sst_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .tick_out    (tick)
   );

   sst_mmss_dec u_seg_dec (
      .value_in    (seg_time_reg),
      .value_out   (seg_dec),
      .zero_out    (seg_zero)
   );

   sst_mmss_dec u_gap_dec (
      .value_in    (gap_time_reg),
      .value_out   (gap_dec),
      .zero_out    (gap_zero)
   );

   // Write decode
   logic wr_cmd;
   logic wr_cfg;
   logic wr_eidx;
   logic wr_eval;
   logic wr_ectl;
   logic wr_entry;
   assign wr_cmd   = wr_in && (addr_in == `SST_OFS_CMD);
   assign wr_cfg   = wr_in && (addr_in == `SST_OFS_CFG);
   assign wr_eidx  = wr_in && (addr_in == `SST_OFS_EIDX);
   assign wr_eval  = wr_in && (addr_in == `SST_OFS_EVAL) && edit_active_reg;
   assign wr_ectl  = wr_in && (addr_in == `SST_OFS_ECTL) && edit_active_reg;
   assign wr_entry = wr_in && (addr_in == `SST_OFS_ENTRY);

   logic cmd_start;
   logic cmd_stop;
   logic cmd_rewind;
   logic cmd_reload;
   logic cmd_next;
   assign cmd_start  = wr_cmd && wdata_in[`SST_CMD_START];
   assign cmd_stop   = wr_cmd && wdata_in[`SST_CMD_STOP];
   assign cmd_rewind = wr_cmd && wdata_in[`SST_CMD_REWIND];
   assign cmd_reload = wr_cmd && wdata_in[`SST_CMD_RELOAD];
   assign cmd_next   = wr_cmd && wdata_in[`SST_CMD_NEXT];

   // Advance to the following segment, wrapping at the end of the range
   logic       at_last;
   logic [6:0] adv_idx;
   logic       adv_run;
   logic       do_adv;
   logic       live;
   assign at_last = (idx_reg == last_reg);
   assign adv_idx = at_last ? first_reg : idx_inc(idx_reg);
   assign adv_run = at_last ? !(halt_last_reg || halt_each_reg) : !halt_each_reg;
   assign live    = seq_active_reg && running_reg && !cmd_stop && tick;
   assign do_adv  = live && (((phase_reg == sst_pkg::PH_SEG) && seg_zero && (gap_reg == '0))
                    || ((phase_reg == sst_pkg::PH_GAP) && gap_zero));

   logic warn_flash;
   logic gap_shown;
   assign warn_flash = (warn_reg != '0) && (phase_reg == sst_pkg::PH_SEG)
                       && (seg_time_reg != '0) && (seg_time_reg <= warn_reg);
   assign gap_shown  = seq_active_reg && gapdisp_reg && (phase_reg == sst_pkg::PH_GAP);

   // Settings
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         gapdisp_reg   <= `SST_RST_GAPDISP;
         halt_each_reg <= `SST_RST_HALT_EACH;
         halt_last_reg <= `SST_RST_HALT_LAST;
         first_reg     <= `SST_RST_FIRST;
         last_reg      <= `SST_RST_LAST;
         gap_reg       <= `SST_RST_GAP;
         warn_reg      <= `SST_RST_WARN;
      end else if (wr_in) begin
         unique case (addr_in)
            `SST_OFS_CFG: begin
               gapdisp_reg   <= wdata_in[`SST_CFG_GAPDISP];
               halt_each_reg <= wdata_in[`SST_CFG_HALT_EACH];
               halt_last_reg <= wdata_in[`SST_CFG_HALT_LAST];
            end
            `SST_OFS_FIRST: first_reg <= idx_clamp(wdata_in[6:0]);
            `SST_OFS_LAST:  last_reg  <= idx_clamp(wdata_in[6:0]);
            `SST_OFS_GAP:   gap_reg   <= wdata_in[`SST_MMSS_W-1:0];
            `SST_OFS_WARN:  warn_reg  <= wdata_in[`SST_MMSS_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Duration table writes from edit mode
   always_ff @(posedge clk_in) begin
      if (wr_eval) begin
         seg_table[edit_idx_reg] <= wdata_in[`SST_MMSS_W-1:0];
      end
   end

   // Edit index and mode
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         edit_active_reg <= 1'b0;
         edit_idx_reg    <= IDX_MIN;
      end else if (wr_eidx) begin
         edit_active_reg <= 1'b1;
         edit_idx_reg    <= idx_clamp(wdata_in[6:0]);
      end else if (wr_eval) begin
         edit_idx_reg    <= idx_inc(edit_idx_reg);
      end else if (wr_ectl) begin
         if (wdata_in[`SST_ECTL_EXIT]) begin
            edit_active_reg <= 1'b0;
         end else if (wdata_in[`SST_ECTL_UP]) begin
            edit_idx_reg <= idx_dec(edit_idx_reg);
         end else if (wdata_in[`SST_ECTL_DOWN]) begin
            edit_idx_reg <= idx_inc(edit_idx_reg);
         end
      end
   end

   // Program selection: power-up code or confirmed entry from a sport program
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         strap_done_reg <= 1'b0;
         seq_active_reg <= 1'b0;
         entry_pend_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         seq_active_reg <= (program_code_in == `SST_PROG_CODE);
      end else if (wr_entry) begin
         if (wdata_in[`SST_ENTRY_LEAVE]) begin
            seq_active_reg <= 1'b0;
            entry_pend_reg <= 1'b0;
         end else if (wdata_in[`SST_ENTRY_REQ] && !main_clock_running_in) begin
            entry_pend_reg <= 1'b1;
         end else if (wdata_in[`SST_ENTRY_YES] && entry_pend_reg && !main_clock_running_in) begin
            seq_active_reg <= 1'b1;
            entry_pend_reg <= 1'b0;
         end else begin
            entry_pend_reg <= 1'b0;
         end
      end
   end

   // Sequencer
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         running_reg   <= 1'b0;
         phase_reg     <= sst_pkg::PH_SEG;
         need_load_reg <= 1'b1;
         idx_reg       <= `SST_RST_FIRST;
         seg_time_reg  <= '0;
         gap_time_reg  <= '0;
      end else if (!seq_active_reg) begin
         running_reg   <= 1'b0;
         need_load_reg <= 1'b1;
      end else if (running_reg) begin
         if (cmd_stop) begin
            running_reg <= 1'b0;
         end else if (do_adv) begin
            idx_reg      <= adv_idx;
            seg_time_reg <= seg_table[adv_idx];
            phase_reg    <= sst_pkg::PH_SEG;
            running_reg  <= adv_run;
         end else if (tick) begin
            unique case (phase_reg)
               sst_pkg::PH_SEG: begin
                  if (seg_zero) begin
                     phase_reg    <= sst_pkg::PH_GAP;
                     gap_time_reg <= gap_reg;
                  end else begin
                     seg_time_reg <= seg_dec;
                  end
               end
               sst_pkg::PH_GAP: gap_time_reg <= gap_dec;
            endcase
         end
      end else begin
         // Rewind and stepping are only honoured while stopped
         if (cmd_start) begin
            running_reg <= 1'b1;
            if (need_load_reg) begin
               idx_reg       <= first_reg;
               seg_time_reg  <= seg_table[first_reg];
               phase_reg     <= sst_pkg::PH_SEG;
               need_load_reg <= 1'b0;
            end
         end else if (cmd_rewind) begin
            idx_reg       <= first_reg;
            seg_time_reg  <= seg_table[first_reg];
            gap_time_reg  <= '0;
            phase_reg     <= sst_pkg::PH_SEG;
            need_load_reg <= 1'b0;
         end else if (cmd_reload) begin
            seg_time_reg <= seg_table[idx_reg];
            phase_reg    <= sst_pkg::PH_SEG;
         end else if (cmd_next) begin
            idx_reg      <= adv_idx;
            seg_time_reg <= seg_table[adv_idx];
            phase_reg    <= sst_pkg::PH_SEG;
         end
      end
   end

   // Display routing
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         display_reg <= '0;
      end else begin
         display_reg.board_time  <= seg_time_reg;
         display_reg.guest_on    <= gap_shown;
         display_reg.guest_time  <= gap_shown ? gap_time_reg : '0;
         display_reg.console_gap <= (phase_reg == sst_pkg::PH_GAP) ? gap_time_reg : '0;
         display_reg.index       <= idx_reg;
         display_reg.index_flash <= gap_shown || (seq_active_reg && warn_flash);
      end
   end

   // Read port: data stand in the cycle after the strobe, unmapped reads as zero
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= '0;
         if (rd_in) begin
            unique case (addr_in)
               `SST_OFS_CFG: begin
                  rdata_reg[`SST_CFG_GAPDISP]   <= gapdisp_reg;
                  rdata_reg[`SST_CFG_HALT_EACH] <= halt_each_reg;
                  rdata_reg[`SST_CFG_HALT_LAST] <= halt_last_reg;
               end
               `SST_OFS_FIRST: rdata_reg[6:0] <= first_reg;
               `SST_OFS_LAST:  rdata_reg[6:0] <= last_reg;
               `SST_OFS_GAP:   rdata_reg[`SST_MMSS_W-1:0] <= gap_reg;
               `SST_OFS_WARN:  rdata_reg[`SST_MMSS_W-1:0] <= warn_reg;
               `SST_OFS_STATUS: begin
                  rdata_reg[`SST_ST_RUN]    <= running_reg;
                  rdata_reg[`SST_ST_GAP]    <= (phase_reg == sst_pkg::PH_GAP);
                  rdata_reg[`SST_ST_ACTIVE] <= seq_active_reg;
                  rdata_reg[`SST_ST_EDIT]   <= edit_active_reg;
                  rdata_reg[`SST_ST_PEND]   <= entry_pend_reg;
                  rdata_reg[`SST_ST_FLASH]  <= display_reg.index_flash;
               end
               `SST_OFS_TIME: begin
                  rdata_reg[`SST_MMSS_W-1:0] <= seg_time_reg;
                  rdata_reg[`SST_TIME_GAP_LSB +: `SST_MMSS_W] <= gap_time_reg;
               end
               `SST_OFS_INDEX: begin
                  rdata_reg[6:0] <= idx_reg;
                  rdata_reg[`SST_INDEX_EDIT_LSB +: 7] <= edit_idx_reg;
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign rdata_out      = rdata_reg;
   assign display_out    = display_reg;
   assign seq_active_out = seq_active_reg;
   assign running_out    = running_reg;

   AST_START_LOAD: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (seq_active_reg && !running_reg && cmd_start && need_load_reg)
      |=> (idx_reg == $past(first_reg)) && running_reg && (phase_reg == sst_pkg::PH_SEG))
      else $error("start did not load the first segment");

   AST_GAP_ENTRY: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (live && (phase_reg == sst_pkg::PH_SEG) && seg_zero && (gap_reg != '0))
      |=> (phase_reg == sst_pkg::PH_GAP) && (gap_time_reg == $past(gap_reg)))
      else $error("gap not loaded after segment end");

   AST_ZERO_GAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (live && (phase_reg == sst_pkg::PH_SEG) && seg_zero && (gap_reg == '0))
      |=> (phase_reg == sst_pkg::PH_SEG) && (idx_reg == $past(adv_idx)))
      else $error("zero gap caused a pause");

   AST_END_REWIND: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (do_adv && at_last) |=> (idx_reg == $past(first_reg))
      && (running_reg == !($past(halt_last_reg) || $past(halt_each_reg))))
      else $error("end of range did not rewind correctly");

   AST_HALT_EACH: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (do_adv && !at_last) |=> (running_reg == !$past(halt_each_reg))
      && (idx_reg == idx_inc($past(idx_reg))))
      else $error("per-segment halt misbehaved");

   AST_REWIND: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (seq_active_reg && !running_reg && cmd_rewind && !cmd_start)
      |=> (idx_reg == $past(first_reg)) && !running_reg)
      else $error("rewind did not restore the first index");

   AST_REWIND_RUN: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (running_reg && cmd_rewind && !do_adv) |=> $stable(idx_reg))
      else $error("rewind acted while running");

   AST_ENTRY_GUARD: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ($past(strap_done_reg) && $rose(seq_active_reg))
      |-> ($past(entry_pend_reg) && !$past(main_clock_running_in)))
      else $error("sequencer entered without confirmation");

   AST_GAP_FLASH: assert property (@(posedge clk_in) disable iff (!resetn_in)
      gap_shown |=> display_reg.index_flash && display_reg.guest_on
      && (display_reg.guest_time == $past(gap_time_reg)))
      else $error("gap on scoreboard without index flash");

   AST_WARN_OFF: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ((warn_reg == '0) && !gap_shown) |=> !display_reg.index_flash)
      else $error("index flashed with warning disabled");

   AST_EDIT_STEP: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (wr_eval && (edit_idx_reg != IDX_MAX)) |=> edit_idx_reg == $past(edit_idx_reg) + 7'h01)
      else $error("enter did not step the edited index");

endmodule : sst_timer
